/* bench/jib_host.sv */
module jib_host (
  output logic o_tck,
  output logic o_trst_n,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_tck = 1'b0;
    o_trst_n = 1'b1;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // Tck stands low between frames; even times keep clear of rising mclk edges
  task automatic step(input logic m, input logic d, output logic q);
    o_tms = m;
    o_tdi = d;
    #32 o_tck = 1'b1;
    q = i_tdo;
    #32 o_tck = 1'b0;
    o_tdi = ~d;
  endtask
  task automatic reset_port();
    #(2 + $time % 2) o_trst_n = 1'b0;
    #40 o_trst_n = 1'b1;
  endtask
  task automatic walk(input logic [7:0] m, input int n);
    logic q;
    #(2 + $time % 2);
    for (int i = 0; i < n; i++) step(m[i], 1'b0, q);
  endtask
  task automatic shift(input int n, input logic [338:0] d, output logic [338:0] q);
    for (int i = 0; i < n; i++) step(i == n - 1, d[i], q[i]);
  endtask
  task automatic scan_ir(input logic [3:0] c, output logic [15:0] cap);
    logic [338:0] q;
    walk(8'h03, 4);
    shift(16, {c, 12'hFFF}, q);
    walk(8'h01, 2);
    cap = q[15:0];
  endtask
  task automatic scan_dr(input int n, input logic [338:0] d, output logic [338:0] q);
    walk(8'h01, 3);
    shift(n, d, q);
    walk(8'h01, 2);
  endtask
endmodule

/* bench/jib_scan_port_asserts.sv */
module jib_scan_port_asserts (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_tck,
  input wire logic i_trst_n,
  input wire logic o_tdo,
  input wire logic o_tdo_oe,
  input wire logic [15:0] o_test_instruction_reg,
  input wire logic o_dbg_irq,
  input wire logic o_wake_req,
  input wire jib_pkg::jib_ins_e o_ins,
  input wire logic [31:0] i_core_d_out,
  input wire logic [31:0] i_core_d_oe,
  input wire logic [31:0] i_pad_d_in,
  input wire logic [31:0] o_pad_d_out,
  input wire logic [31:0] o_pad_d_oe,
  input wire logic [31:0] o_core_d_in,
  input wire logic o_extest
);
  import jib_pkg::*;
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);
  unused_ones_a:
    assert property (o_test_instruction_reg[11:0] == 12'hFFF) else $error("unused bits low");
  irq_pulse_a:
    assert property (o_dbg_irq |=> !o_dbg_irq) else $error("irq pulse too long");
  wake_pulse_a:
    assert property (o_wake_req |=> !o_wake_req) else $error("wake pulse too long");
  trst_idle_a:
    assert property (!i_trst_n |-> !o_tdo_oe && !o_extest && o_ins == JIB_INS_BYPASS)
      else $error("port not reset");
  // Async test reset may move outputs mid tck-high, so it masks these
  tdo_fall_a:
    assert property (disable iff (i_sys_rst || !i_trst_n)
      $changed({o_tdo, o_tdo_oe}) |-> !i_tck) else $error("tdo moved with tck high");
  ins_fall_a:
    assert property (disable iff (i_sys_rst || !i_trst_n)
      $changed(o_ins) |-> !i_tck) else $error("instruction moved with tck high");
  extest_ins_a:
    assert property (disable iff (i_sys_rst || !i_trst_n)
      o_extest == (o_ins == JIB_INS_EXTEST)) else $error("extest flag mismatch");
  pad_core_a:
    assert property (!o_extest |-> o_pad_d_out == i_core_d_out && o_pad_d_oe == i_core_d_oe)
      else $error("pads not from core");
  core_in_a:
    assert property (o_core_d_in == i_pad_d_in) else $error("core input not from pad");
  cover property (o_dbg_irq);
  cover property (o_wake_req);
  cover property (o_extest);
  cover property (o_tdo_oe);
endmodule

bind jib_scan_port jib_scan_port_asserts u_chk (
  .i_mclk, .i_sys_rst, .i_tck, .i_trst_n, .o_tdo, .o_tdo_oe, .o_test_instruction_reg,
  .o_dbg_irq, .o_wake_req, .o_ins, .i_core_d_out, .i_core_d_oe, .i_pad_d_in,
  .o_pad_d_out, .o_pad_d_oe, .o_core_d_in, .o_extest
);

/* bench/tb_jtag_instruction_and_boundary_chain.sv */
module tb_jtag_instruction_and_boundary_chain;
  timeunit 1ns;
  timeprecision 1ns;
  import jib_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic tck;
  logic trst_n;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic [15:0] ir;
  logic dbg_rst;
  logic dbg_irq;
  logic wake;
  jib_ins_e ins;
  logic [31:0] core_out = 32'h0F0F_3C3C;
  logic [31:0] core_oe = 32'hFF00_00FF;
  logic [31:0] pad_in = 32'hA5C3_0F96;
  logic [31:0] pad_out;
  logic [31:0] pad_oe;
  logic [31:0] core_in;
  logic [7:0] misc = 8'h5A;
  logic [234:0] oth = {47{5'h16}};
  logic [234:0] upd;
  logic extest;
  int failures = 0;
  int checked = 0;
  int irq_n = 0;
  int wake_n = 0;
  // Released line reads inverted so a sample outside shifting shows up
  wire tdo_w = tdo_oe ? tdo : ~tdo;
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    irq_n <= irq_n + int'(dbg_irq === 1'b1);
    wake_n <= wake_n + int'(wake === 1'b1);
  end
  jib_host host (.o_tck(tck), .o_trst_n(trst_n), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_w));
  jib_scan_port dut (
    .i_mclk(mclk), .i_sys_rst(sys_rst), .i_tck(tck), .i_trst_n(trst_n), .i_tms(tms),
    .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_test_instruction_reg(ir),
    .o_dbg_rst(dbg_rst), .o_dbg_irq(dbg_irq), .o_wake_req(wake), .o_ins(ins),
    .i_core_d_out(core_out), .i_core_d_oe(core_oe), .i_pad_d_in(pad_in),
    .o_pad_d_out(pad_out), .o_pad_d_oe(pad_oe), .o_core_d_in(core_in),
    .i_misc_in_cap(misc), .i_other_cap(oth), .o_other_upd(upd), .o_extest(extest)
  );
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [338:0] got, input logic [338:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  // Core copy crosses domains, so it is polled with a bound
  task automatic wait_ir(input logic [15:0] e);
    for (int i = 0; i < 20 && ir !== e; i++) @(posedge mclk);
    chk(ir, e);
    if (ir !== e) end_sim();
  endtask
  task automatic t_bypass();
    logic [338:0] q;
    chk(ir, 16'hFFFF);
    chk(ins, JIB_INS_BYPASS);
    host.scan_dr(8, 339'hB5, q);
    chk(q[7:0], 8'h6A);
    $display("bypass test done");
  endtask
  task automatic t_codes();
    logic [3:0] c [8] = '{4'h0, 4'h4, 4'h6, 4'h7, 4'hA, 4'hB, 4'h1, 4'hF};
    jib_ins_e e [8] = '{JIB_INS_EXTEST, JIB_INS_SAMPLE, JIB_INS_DRST_OFF, JIB_INS_DRST_ON,
      JIB_INS_IRQ, JIB_INS_IRQ, JIB_INS_WAKE, JIB_INS_BYPASS};
    logic [15:0] cap;
    logic [15:0] prev;
    int n;
    prev = 16'hFFFF;
    for (int i = 0; i < 8; i++)
    begin
      n = irq_n * 16 + wake_n;
      host.scan_ir(c[i], cap);
      chk(cap, prev);
      chk(ins, e[i]);
      wait_ir({c[i], 12'hFFF});
      repeat (4) @(posedge mclk);
      chk(irq_n * 16 + wake_n - n, (c[i][3:1] == 3'h5) ? 16 : (c[i] == 4'h1));
      chk(dbg_rst, i >= 3);
      prev = {c[i], 12'hFFF};
    end
    $display("code test done");
  endtask
  task automatic t_chain();
    logic [15:0] cap;
    logic [338:0] d;
    logic [338:0] q;
    d = {32'h0, 8'h0, 32'h1234_5678, 32'hFFFF_0000, {47{5'h09}}};
    host.scan_ir(4'h4, cap);
    host.scan_dr(339, d, q);
    chk(q[338:299], {pad_in, misc});
    chk(q[298:235], {core_out, ~core_oe});
    chk(q[234:0], oth);
    chk(core_in, pad_in);
    host.scan_ir(4'h0, cap);
    chk(extest, 1'b1);
    chk(pad_out, 32'h1234_5678);
    chk(pad_oe, 32'h0000_FFFF);
    chk(upd, d[234:0]);
    $display("chain test done");
  endtask
  task automatic t_resets();
    logic [15:0] cap;
    host.scan_ir(4'h7, cap);
    host.walk(8'h1F, 6);
    wait_ir(16'hFFFF);
    chk(ins, JIB_INS_BYPASS);
    host.walk(8'h00, 1);
    host.scan_ir(4'h0, cap);
    host.reset_port();
    chk(extest, 1'b0);
    chk(ins, JIB_INS_BYPASS);
    wait_ir(16'hFFFF);
    host.walk(8'h00, 1);
    $display("reset test done");
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    #1 sys_rst = 1'b0;
    host.reset_port();
    host.walk(8'h00, 1);
    t_bypass();
    t_codes();
    t_chain();
    t_resets();
    end_sim();
  end
endmodule

/* design/jib_map.svh */
`ifndef JIB_MAP_SVH
`define JIB_MAP_SVH

// Instruction register
`define JIB_IR_W 16
`define JIB_IR_RST 16'hFFFF
`define JIB_IR_CODE_HI 15
`define JIB_IR_CODE_LO 12
`define JIB_IR_UNUSED 12'hFFF

// Instruction codes, bits 15:12
`define JIB_CODE_EXTEST 4'h0
`define JIB_CODE_WAKE 4'h1
`define JIB_CODE_SAMPLE 4'h4
`define JIB_CODE_DRST_OFF 4'h6
`define JIB_CODE_DRST_ON 4'h7
`define JIB_CODE_IRQ_HI 3'h5
`define JIB_CODE_BYPASS 4'hF

// Pin scan chain layout
`define JIB_BSR_LEN 339
`define JIB_BSR_TOP 338
`define JIB_BSR_DIN_HI 338
`define JIB_BSR_DIN_LO 307
`define JIB_BSR_MISC_HI 306
`define JIB_BSR_MISC_LO 299
`define JIB_BSR_DOUT_HI 298
`define JIB_BSR_DOUT_LO 267
`define JIB_BSR_DCTL_HI 266
`define JIB_BSR_DCTL_LO 235
`define JIB_BSR_OTHER_HI 234

// Clock-domain event sync width
`define JIB_SYNC_W 5

`endif

/* design/jib_pkg.sv */
package jib_pkg;

  typedef enum logic [3:0] {
    JIB_TLR,
    JIB_RTI,
    JIB_SEL_DR,
    JIB_CAP_DR,
    JIB_SHIFT_DR,
    JIB_EXIT1_DR,
    JIB_PAUSE_DR,
    JIB_EXIT2_DR,
    JIB_UPD_DR,
    JIB_SEL_IR,
    JIB_CAP_IR,
    JIB_SHIFT_IR,
    JIB_EXIT1_IR,
    JIB_PAUSE_IR,
    JIB_EXIT2_IR,
    JIB_UPD_IR
  } jib_tap_e;

  typedef enum logic [2:0] {
    JIB_INS_EXTEST,
    JIB_INS_SAMPLE,
    JIB_INS_BYPASS,
    JIB_INS_DRST_OFF,
    JIB_INS_DRST_ON,
    JIB_INS_IRQ,
    JIB_INS_WAKE,
    JIB_INS_RSVD
  } jib_ins_e;

endpackage

/* design/jib_scan_port.sv */
`include "jib_map.svh"

// Behaviour
// R01 - 16-bit instruction register, core reads only
// R02 - Reinit on test reset or Test-Logic-Reset
// R03 - Reinit value all ones, code selects bypass
// R04 - Scan port may load instruction anytime
// R05 - Host never loads reserved instruction codes
// R06 - Code field written only by scan port
// R07 - Decode 0000 extest, 0100 sample, 1111 bypass
// R08 - Vendor codes: reset release/assert, irq, wake
// R09 - Unused bits 11..0 always read one
// R10 - Pin scan chain is pad shift register
// R11 - Extest/sample put chain between TDI, TDO
// R12 - Chain cells 338 at TDI to 0
// R13 - Data bus in, out, control cells
// R14 - Control cell low drives pin from out
// R15 - Rising edge samples TMS/TDI, falling shifts
// R16 - Low test reset resets port asynchronously
// R17 - Bypass puts one-bit register on path
// R18 - Shift in Shift-IR, apply on Update-IR
module jib_scan_port (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_tck,
  input wire logic i_trst_n,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic [15:0] o_test_instruction_reg,
  output logic o_dbg_rst,
  output logic o_dbg_irq,
  output logic o_wake_req,
  output jib_pkg::jib_ins_e o_ins,
  input wire logic [31:0] i_core_d_out,
  input wire logic [31:0] i_core_d_oe,
  input wire logic [31:0] i_pad_d_in,
  output logic [31:0] o_pad_d_out,
  output logic [31:0] o_pad_d_oe,
  output logic [31:0] o_core_d_in,
  input wire logic [7:0] i_misc_in_cap,
  input wire logic [234:0] i_other_cap,
  output logic [234:0] o_other_upd,
  output logic o_extest
);
  import jib_pkg::*;

  jib_tap_e state;
  jib_ins_e ins;
  jib_ins_e upd_ins;
  logic tck_rst;
  logic sel_bsr;

  // Rising-edge group
  logic tdi_s;
  logic shift_ir_pend;
  logic shift_dr_pend;
  logic next_tdi_s;
  logic next_shift_ir_pend;
  logic next_shift_dr_pend;

  // Falling-edge group
  logic [15:0] ir_sh;
  logic [15:0] ir;
  logic [338:0] bs_sh;
  logic [338:0] bs_upd;
  logic byp;
  logic tdo;
  logic tdo_oe;
  logic extest;
  logic drst;
  logic irq_tog;
  logic wake_tog;
  logic ir_tog;
  logic [15:0] next_ir_sh;
  logic [15:0] next_ir;
  logic [338:0] next_bs_sh;
  logic [338:0] next_bs_upd;
  logic next_byp;
  logic next_tdo;
  logic next_tdo_oe;
  logic next_extest;
  logic next_drst;
  logic next_irq_tog;
  logic next_wake_tog;
  logic next_ir_tog;

  // Capture path
  logic [338:0] cap_raw;
  logic [338:0] cap_s;

  // System clock group
  logic [4:0] evt_s;
  logic [2:0] tog_q;
  logic [15:0] ir_copy;
  logic dbg_rst;
  logic dbg_irq;
  logic wake_req;
  logic [2:0] next_tog_q;
  logic [15:0] next_ir_copy;
  logic next_dbg_rst;
  logic next_dbg_irq;
  logic next_wake_req;

  assign tck_rst = ~i_trst_n;

  jib_tap u_tap (
    .i_tck(i_tck),
    .i_trst_n(i_trst_n),
    .i_tms(i_tms),
    .o_state(state)
  );

  // Decoder shared by current and freshly updated code
  function automatic jib_ins_e decode(input logic [3:0] code);
    jib_ins_e d;
    d = JIB_INS_RSVD; // R05
    if (code == `JIB_CODE_EXTEST)
      d = JIB_INS_EXTEST; // R07
    else if (code == `JIB_CODE_SAMPLE)
      d = JIB_INS_SAMPLE; // R07
    else if (code == `JIB_CODE_BYPASS)
      d = JIB_INS_BYPASS; // R07
    else if (code == `JIB_CODE_DRST_OFF)
      d = JIB_INS_DRST_OFF; // R08
    else if (code == `JIB_CODE_DRST_ON)
      d = JIB_INS_DRST_ON; // R08
    else if (code[3:1] == `JIB_CODE_IRQ_HI)
      d = JIB_INS_IRQ; // R08
    else if (code == `JIB_CODE_WAKE)
      d = JIB_INS_WAKE; // R08
    return d;
  endfunction

  assign ins = decode(ir[`JIB_IR_CODE_HI:`JIB_IR_CODE_LO]);
  assign upd_ins = decode(ir_sh[`JIB_IR_CODE_HI:`JIB_IR_CODE_LO]);
  assign o_ins = ins;
  // Only the two boundary instructions route through the pin chain
  assign sel_bsr = (ins == JIB_INS_EXTEST) || (ins == JIB_INS_SAMPLE); // R11

  // Chain order: pad data in, misc inputs, core data out, control, rest
  assign cap_raw = {i_pad_d_in, i_misc_in_cap, i_core_d_out, ~i_core_d_oe, i_other_cap}; // R13

  // Pads and core are not on the test clock
  jib_sync2 #(.W(`JIB_BSR_LEN)) u_cap_sync (
    .i_clk(i_tck),
    .i_rst(tck_rst),
    .i_d(cap_raw),
    .o_q(cap_s)
  );

  always_comb
  begin
    next_tdi_s = i_tdi; // R15
    next_shift_ir_pend = (state == JIB_SHIFT_IR);
    next_shift_dr_pend = (state == JIB_SHIFT_DR);
  end

  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      tdi_s <= 1'b0;
      shift_ir_pend <= 1'b0;
      shift_dr_pend <= 1'b0;
    end
    else
    begin
      tdi_s <= next_tdi_s;
      shift_ir_pend <= next_shift_ir_pend;
      shift_dr_pend <= next_shift_dr_pend;
    end
  end

  always_comb
  begin
    next_ir_sh = ir_sh;
    next_ir = ir;
    next_bs_sh = bs_sh;
    next_bs_upd = bs_upd;
    next_byp = byp;
    next_drst = drst;
    next_irq_tog = irq_tog;
    next_wake_tog = wake_tog;
    next_ir_tog = ir_tog;
    case (state)
      JIB_TLR:
      begin
        if (ir != `JIB_IR_RST)
        begin
          next_ir = `JIB_IR_RST; // R02 R03
          next_ir_tog = ~ir_tog;
        end
      end
      JIB_CAP_IR: next_ir_sh = ir;
      JIB_CAP_DR:
      begin
        if (sel_bsr)
          next_bs_sh = cap_s; // R10
        else
          next_byp = 1'b0; // R17
      end
      JIB_UPD_IR:
      begin
        // Lower field forced to ones whatever was shifted in
        next_ir = {ir_sh[`JIB_IR_CODE_HI:`JIB_IR_CODE_LO], `JIB_IR_UNUSED}; // R18 R09 R04
        next_ir_tog = ~ir_tog;
        if (upd_ins == JIB_INS_DRST_ON)
          next_drst = 1'b1; // R08
        else if (upd_ins == JIB_INS_DRST_OFF)
          next_drst = 1'b0; // R08
        else if (upd_ins == JIB_INS_IRQ)
          next_irq_tog = ~irq_tog; // R08
        else if (upd_ins == JIB_INS_WAKE)
          next_wake_tog = ~wake_tog; // R08
      end
      JIB_UPD_DR:
      begin
        if (sel_bsr)
          next_bs_upd = bs_sh; // R11
      end
      default:
      begin
      end
    endcase
    // Bit sampled at the last rising edge moves in now
    if (shift_ir_pend)
      next_ir_sh = {tdi_s, ir_sh[15:1]}; // R18 R15
    else if (shift_dr_pend && sel_bsr)
      next_bs_sh = {tdi_s, bs_sh[`JIB_BSR_TOP:1]}; // R12 R15
    else if (shift_dr_pend)
      next_byp = tdi_s; // R17
    if (state == JIB_SHIFT_IR || state == JIB_CAP_IR || state == JIB_EXIT2_IR)
      next_tdo = next_ir_sh[0];
    else if (sel_bsr)
      next_tdo = next_bs_sh[0]; // R11
    else
      next_tdo = next_byp; // R17
    next_tdo_oe = (state == JIB_SHIFT_IR) || (state == JIB_SHIFT_DR);
    next_extest = (decode(next_ir[`JIB_IR_CODE_HI:`JIB_IR_CODE_LO]) == JIB_INS_EXTEST);
  end

  // Shifting and TDO move on the falling edge
  always_ff @(negedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
    begin
      ir_sh <= `JIB_IR_RST;
      ir <= `JIB_IR_RST; // R02 R16
      bs_sh <= '0;
      bs_upd <= '0;
      byp <= 1'b0;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
      extest <= 1'b0;
      drst <= 1'b0;
      irq_tog <= 1'b0;
      wake_tog <= 1'b0;
      ir_tog <= 1'b0;
    end
    else
    begin
      ir_sh <= next_ir_sh;
      ir <= next_ir;
      bs_sh <= next_bs_sh;
      bs_upd <= next_bs_upd;
      byp <= next_byp;
      tdo <= next_tdo; // R15
      tdo_oe <= next_tdo_oe;
      extest <= next_extest;
      drst <= next_drst;
      irq_tog <= next_irq_tog;
      wake_tog <= next_wake_tog;
      ir_tog <= next_ir_tog;
    end
  end

  assign o_tdo = tdo;
  assign o_tdo_oe = tdo_oe;
  assign o_extest = extest;
  assign o_other_upd = bs_upd[`JIB_BSR_OTHER_HI:0];
  assign o_core_d_in = i_pad_d_in;
  // Extest hands the data pads to the chain; control cells are active low
  assign o_pad_d_out = extest ? bs_upd[`JIB_BSR_DOUT_HI:`JIB_BSR_DOUT_LO] : i_core_d_out; // R14
  assign o_pad_d_oe = extest ? ~bs_upd[`JIB_BSR_DCTL_HI:`JIB_BSR_DCTL_LO] : i_core_d_oe; // R14

  // Events cross as toggles, the reset request as a level
  jib_sync2 #(.W(`JIB_SYNC_W)) u_evt_sync (
    .i_clk(i_mclk),
    .i_rst(i_sys_rst),
    .i_d({tck_rst, drst, wake_tog, irq_tog, ir_tog}),
    .o_q(evt_s)
  );

  always_comb
  begin
    next_tog_q = evt_s[2:0];
    // Code word is stable for many test clocks after its toggle
    next_ir_copy = (evt_s[0] != tog_q[0]) ? ir : ir_copy; // R01
    // Test reset clears toggles silently; must span one system clock
    if (evt_s[4])
      next_ir_copy = `JIB_IR_RST; // R02
    next_dbg_irq = !evt_s[4] && (evt_s[1] != tog_q[1]);
    next_wake_req = !evt_s[4] && (evt_s[2] != tog_q[2]);
    next_dbg_rst = evt_s[3];
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tog_q <= '0;
      ir_copy <= `JIB_IR_RST; // R03
      dbg_rst <= 1'b0;
      dbg_irq <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      tog_q <= next_tog_q;
      ir_copy <= next_ir_copy;
      dbg_rst <= next_dbg_rst;
      dbg_irq <= next_dbg_irq;
      wake_req <= next_wake_req;
    end
  end

  // Read-only to the core: no write path exists
  assign o_test_instruction_reg = ir_copy; // R01 R06
  assign o_dbg_rst = dbg_rst;
  assign o_dbg_irq = dbg_irq;
  assign o_wake_req = wake_req;

endmodule

/* design/jib_sync2.sv */
module jib_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // First stage feeds only the second
  always_comb
  begin
    next_meta = i_d;
    next_q = meta;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta <= '0;
      o_q <= '0;
    end
    else
    begin
      meta <= next_meta;
      o_q <= next_q;
    end
  end

endmodule

/* design/jib_tap.sv */
module jib_tap (
  input wire logic i_tck,
  input wire logic i_trst_n,
  input wire logic i_tms,
  output jib_pkg::jib_tap_e o_state
);
  import jib_pkg::*;

  jib_tap_e next_state;

  always_comb
  begin
    next_state = o_state;
    case (o_state)
      JIB_TLR: next_state = i_tms ? JIB_TLR : JIB_RTI;
      JIB_RTI: next_state = i_tms ? JIB_SEL_DR : JIB_RTI;
      JIB_SEL_DR: next_state = i_tms ? JIB_SEL_IR : JIB_CAP_DR;
      JIB_CAP_DR: next_state = i_tms ? JIB_EXIT1_DR : JIB_SHIFT_DR;
      JIB_SHIFT_DR: next_state = i_tms ? JIB_EXIT1_DR : JIB_SHIFT_DR;
      JIB_EXIT1_DR: next_state = i_tms ? JIB_UPD_DR : JIB_PAUSE_DR;
      JIB_PAUSE_DR: next_state = i_tms ? JIB_EXIT2_DR : JIB_PAUSE_DR;
      JIB_EXIT2_DR: next_state = i_tms ? JIB_UPD_DR : JIB_SHIFT_DR;
      JIB_UPD_DR: next_state = i_tms ? JIB_SEL_DR : JIB_RTI;
      JIB_SEL_IR: next_state = i_tms ? JIB_TLR : JIB_CAP_IR;
      JIB_CAP_IR: next_state = i_tms ? JIB_EXIT1_IR : JIB_SHIFT_IR;
      JIB_SHIFT_IR: next_state = i_tms ? JIB_EXIT1_IR : JIB_SHIFT_IR;
      JIB_EXIT1_IR: next_state = i_tms ? JIB_UPD_IR : JIB_PAUSE_IR;
      JIB_PAUSE_IR: next_state = i_tms ? JIB_EXIT2_IR : JIB_PAUSE_IR;
      JIB_EXIT2_IR: next_state = i_tms ? JIB_UPD_IR : JIB_SHIFT_IR;
      JIB_UPD_IR: next_state = i_tms ? JIB_SEL_DR : JIB_RTI;
      default: next_state = JIB_TLR;
    endcase
  end

  // Advances on TMS at the rising edge; low test reset forces reset state
  always_ff @(posedge i_tck or negedge i_trst_n)
  begin
    if (!i_trst_n)
      o_state <= JIB_TLR; // R16
    else
      o_state <= next_state; // R15
  end

endmodule
